/* File: verilog/chsc_pkg.sv */
// package: shared constants and types for the card host signal control ends
package chsc_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int DATA_W      = 16;
	localparam int ADDR_W      = 11;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	// card busy time after reset, in ns
	localparam int INIT_TIME_NS  = 2000;
	localparam int INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CNT_W    = 9;
	// host strobe low time, in ns
	localparam int STROBE_TIME_NS = 80;
	localparam int STROBE_CYCLES  = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STB_CNT_W      = 5;
	// pulse mode interrupt width, in ns
	localparam int IRQ_PULSE_NS     = 40;
	localparam int IRQ_PULSE_CYCLES = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IRQ_CNT_W        = 4;

	// ----------------------------------------
	// modes
	// ----------------------------------------
	localparam logic [1:0] MODE_MEM  = 2'h0;
	localparam logic [1:0] MODE_IO   = 2'h1;
	localparam logic [1:0] MODE_TASK = 2'h2;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

	// ----------------------------------------
	// host sequencer states
	// ----------------------------------------
	typedef enum logic [4:0] {
		H_IDLE  = 5'b00001,
		H_WRITE = 5'b00010,
		H_READ  = 5'b00100,
		H_DMA   = 5'b01000,
		H_UDMA  = 5'b10000
	} chsc_host_state_t;

endpackage : chsc_pkg

/* File: verilog/chsc_if.sv */
// interface: control pins between the card end and the host end
`timescale 1ns/1ps
interface chsc_if;
	import chsc_pkg::*;

	logic              io_write_strobe_n;
	logic              output_enable_strobe_n;
	logic              attribute_space_select_n;
	logic              ide_mode_select_n;
	logic              burst_stop;
	logic              dma_acknowledge;
	logic              reset_pin;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] host_data;
	logic [DATA_W-1:0] card_data;
	logic              card_data_oe_n;
	logic              ready;
	logic              io_interrupt_request_n;
	logic              ide_interrupt_line;
	logic              dma_request;

	modport card (
		input  io_write_strobe_n, output_enable_strobe_n, attribute_space_select_n,
		input  ide_mode_select_n, burst_stop, dma_acknowledge, reset_pin, addr, host_data,
		output card_data, card_data_oe_n, ready, io_interrupt_request_n,
		output ide_interrupt_line, dma_request
	);
	modport host (
		output io_write_strobe_n, output_enable_strobe_n, attribute_space_select_n,
		output ide_mode_select_n, burst_stop, dma_acknowledge, reset_pin, addr, host_data,
		input  card_data, card_data_oe_n, ready, io_interrupt_request_n,
		input  ide_interrupt_line, dma_request
	);
endinterface : chsc_if

/* File: verilog/chsc_card.sv */
// module: card end of the host control signals
//
// Operation
// - io mode latches data on write strobe
// - capture on rising trailing strobe edge
// - memory mode ignores write strobe
// - host negates write strobe before ultra dma
// - burst stop ends ultra dma burst
// - memory mode output enable drives read data
// - io mode output enable reads config only
// - host grounds mode select for task mode
// - ready high when idle, low busy
// - ready low until reset sequence done
// - host waits for ready before access
// - stuck reset pin at power-on not disabled; enable arms on the first clock, so a stuck pin still resets
// - io interrupt pulse or level low
// - task mode interrupt active high
// - space select high common, low attribute
// - memory udma keeps space select negated
// - io write cycles drive space select low
// - io udma keeps space select asserted
// - acknowledge only answers request, starts dma
// - task mode ignores acknowledge when idle
// - request held until acknowledge, reasserted later
// - dma keeps space select negated except io udma, 16-bit
`timescale 1ns/1ps
module chsc_card
	import chsc_pkg::*;
(
	input  wire logic              REF_CLK,
	input  wire logic              RST_N,
	chsc_if.card                   LINK,
	input  wire logic              IO_CONFIGURED,
	input  wire logic              UDMA_ACTIVE,
	input  wire logic              IRQ_LEVEL_MODE,
	input  wire logic              IRQ_EVENT,
	input  wire logic              DMA_PENDING,
	input  wire logic              BUSY,
	input  wire logic [DATA_W-1:0] READ_DATA,
	input  wire logic [DATA_W-1:0] CONFIG_DATA,
	output logic      [DATA_W-1:0] WRITE_DATA,
	output logic      [ADDR_W-1:0] WRITE_ADDR,
	output logic                   WRITE_VALID,
	output logic                   ATTR_ACCESS,
	output logic                   BURST_END,
	output logic                   DMA_START,
	output logic      [1:0]        MODE
);

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [1:0] sync_io_write_strobe;
	logic [1:0] sync_oe;
	logic [1:0] sync_stop;
	logic [1:0] sync_ack;
	logic [1:0] sync_rst;
	logic       io_write_strobe_q;
	logic       stop_q;
	logic       ack_q;
	logic       irq_ev_q;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync_io_write_strobe <= 2'h3;
			sync_oe   <= 2'h3;
			sync_stop <= 2'h0;
			sync_ack  <= 2'h0;
			sync_rst  <= 2'h0;
		end else begin
			sync_io_write_strobe <= {sync_io_write_strobe[0], LINK.io_write_strobe_n};
			sync_oe   <= {sync_oe[0], LINK.output_enable_strobe_n};
			sync_stop <= {sync_stop[0], LINK.burst_stop};
			sync_ack  <= {sync_ack[0], LINK.dma_acknowledge};
			sync_rst  <= {sync_rst[0], LINK.reset_pin};
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			io_write_strobe_q   <= 1'b1;
			stop_q   <= 1'b0;
			ack_q    <= 1'b0;
			irq_ev_q <= 1'b0;
		end else begin
			io_write_strobe_q   <= sync_io_write_strobe[1];
			stop_q   <= sync_stop[1];
			ack_q    <= sync_ack[1];
			irq_ev_q <= IRQ_EVENT;
		end
	end

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	logic [1:0] next_mode;

	always_comb begin
		if (!LINK.ide_mode_select_n)
			next_mode = MODE_TASK;
		else if (IO_CONFIGURED)
			next_mode = MODE_IO;
		else
			next_mode = MODE_MEM;
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			MODE <= MODE_MEM;
		else
			MODE <= next_mode;
	end

	// ----------------------------------------
	// reset pin and ready
	// ----------------------------------------
	logic                  pin_rst_enabled;
	logic                  pin_rst;
	logic [INIT_CNT_W-1:0] init_cnt;

	// reset pin enable arms on the first clock (sync_rst resets low), so a pin stuck from power-on still resets
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_rst_enabled <= 1'b0;
		end else if (!sync_rst[1]) begin
			pin_rst_enabled <= 1'b1;
		end
	end

	assign pin_rst = pin_rst_enabled && sync_rst[1];

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			init_cnt <= INIT_CNT_W'(INIT_CYCLES);
		else if (pin_rst)
			init_cnt <= INIT_CNT_W'(INIT_CYCLES);
		else if (init_cnt != '0)
			init_cnt <= init_cnt - 1'b1;
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			LINK.ready <= 1'b0;
		else
			LINK.ready <= (init_cnt == '0) && !pin_rst && !BUSY;
	end

	// ----------------------------------------
	// write strobe capture
	// ----------------------------------------
	logic io_write_strobe_rise;
	logic write_allowed;

	assign io_write_strobe_rise     = sync_io_write_strobe[1] && !io_write_strobe_q;
	assign write_allowed = (MODE != MODE_MEM) && !UDMA_ACTIVE && LINK.ready;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			WRITE_DATA  <= DATA_RST;
			WRITE_ADDR  <= '0;
			WRITE_VALID <= 1'b0;
		end else begin
			WRITE_VALID <= 1'b0;
			if (io_write_strobe_rise && write_allowed) begin
				WRITE_DATA  <= LINK.host_data;
				WRITE_ADDR  <= LINK.addr;
				WRITE_VALID <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// read data drive
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LINK.card_data     <= DATA_RST;
			LINK.card_data_oe_n <= 1'b1;
			ATTR_ACCESS        <= 1'b0;
		end else if (!sync_oe[1] && MODE == MODE_MEM) begin
			ATTR_ACCESS        <= !LINK.attribute_space_select_n;
			LINK.card_data     <= LINK.attribute_space_select_n ? READ_DATA : CONFIG_DATA;
			LINK.card_data_oe_n <= 1'b0;
		end else if (!sync_oe[1] && MODE == MODE_IO) begin
			ATTR_ACCESS        <= 1'b1;
			LINK.card_data     <= CONFIG_DATA;
			LINK.card_data_oe_n <= 1'b0;
		end else begin
			LINK.card_data_oe_n <= 1'b1;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	logic [IRQ_CNT_W-1:0] irq_cnt;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			irq_cnt <= '0;
		else if (IRQ_EVENT && !irq_ev_q && !IRQ_LEVEL_MODE)
			irq_cnt <= IRQ_CNT_W'(IRQ_PULSE_CYCLES);
		else if (irq_cnt != '0)
			irq_cnt <= irq_cnt - 1'b1;
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			LINK.io_interrupt_request_n <= 1'b1;
		else if (MODE == MODE_IO)
			LINK.io_interrupt_request_n <= IRQ_LEVEL_MODE ? !IRQ_EVENT : (irq_cnt == '0);
		else
			LINK.io_interrupt_request_n <= 1'b1;
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			LINK.ide_interrupt_line <= 1'b0;
		else
			LINK.ide_interrupt_line <= (MODE == MODE_TASK) && IRQ_EVENT;
	end

	// ----------------------------------------
	// dma handshake and burst stop
	// ----------------------------------------
	logic dma_req;
	logic dma_active;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			dma_req <= 1'b0;
		else if (dma_req && sync_ack[1])
			dma_req <= 1'b0;
		else if (!dma_req && !sync_ack[1] && DMA_PENDING && LINK.ready)
			dma_req <= 1'b1;
	end

	assign LINK.dma_request = dma_req;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			dma_active <= 1'b0;
			DMA_START  <= 1'b0;
		end else begin
			DMA_START <= dma_req && sync_ack[1] && !ack_q;
			if (dma_req && sync_ack[1] && !ack_q)
				dma_active <= 1'b1;
			else if (!sync_ack[1])
				dma_active <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			BURST_END <= 1'b0;
		else
			BURST_END <= UDMA_ACTIVE && dma_active && sync_stop[1] && !stop_q;
	end

endmodule : chsc_card

/* File: verilog/chsc_host.sv */
// module: host end of the card control signals
`timescale 1ns/1ps
module chsc_host
	import chsc_pkg::*;
(
	input  wire logic              REF_CLK,
	input  wire logic              RST_N,
	chsc_if.host                   LINK,
	input  wire logic              TASK_MODE,
	input  wire logic              IO_MODE,
	input  wire logic              UDMA_ENABLE,
	input  wire logic              WR_REQ,
	input  wire logic              RD_REQ,
	input  wire logic              ATTR_SEL,
	input  wire logic              STOP_REQ,
	input  wire logic [ADDR_W-1:0] REQ_ADDR,
	input  wire logic [DATA_W-1:0] REQ_DATA,
	output logic                   REQ_READY,
	output logic                   DONE,
	output logic      [DATA_W-1:0] RD_DATA,
	output logic                   CARD_IRQ
);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	chsc_host_state_t     state;
	chsc_host_state_t     next_state;
	logic [STB_CNT_W-1:0] cnt;
	logic                 cnt_done;

	assign cnt_done  = (cnt == '0);
	assign REQ_READY = (state == H_IDLE) && LINK.ready && !LINK.dma_request;

	always_comb begin
		next_state = state;
		case (state)
			H_IDLE: begin
				if (LINK.dma_request)
					next_state = UDMA_ENABLE ? H_UDMA : H_DMA;
				else if (REQ_READY && WR_REQ)
					next_state = H_WRITE;
				else if (REQ_READY && RD_REQ)
					next_state = H_READ;
			end
			H_WRITE: if (cnt_done) next_state = H_IDLE;
			H_READ:  if (cnt_done) next_state = H_IDLE;
			H_DMA:   if (cnt_done) next_state = H_IDLE;
			H_UDMA:  if (STOP_REQ || cnt_done) next_state = H_IDLE;
			default: next_state = H_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			state <= H_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			cnt <= '0;
		else if (state == H_IDLE && next_state != H_IDLE)
			cnt <= STB_CNT_W'(STROBE_CYCLES);
		else if (!cnt_done)
			cnt <= cnt - 1'b1;
	end

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LINK.io_write_strobe_n        <= 1'b1;
			LINK.output_enable_strobe_n   <= 1'b1;
			LINK.attribute_space_select_n <= 1'b1;
			LINK.ide_mode_select_n        <= 1'b1;
			LINK.burst_stop               <= 1'b0;
			LINK.dma_acknowledge          <= 1'b0;
			LINK.reset_pin                <= 1'b0;
			LINK.addr                     <= '0;
			LINK.host_data                <= DATA_RST;
		end else begin
			LINK.ide_mode_select_n <= !TASK_MODE;
			LINK.io_write_strobe_n      <= !(next_state == H_WRITE);
			LINK.output_enable_strobe_n <= !(next_state == H_READ);
			LINK.dma_acknowledge <= (next_state == H_DMA) || (next_state == H_UDMA);
			LINK.burst_stop      <= (state == H_UDMA) && STOP_REQ;
			if (next_state == H_UDMA || next_state == H_DMA)
				LINK.attribute_space_select_n <= !(IO_MODE && UDMA_ENABLE);
			else if (IO_MODE && next_state == H_WRITE)
				LINK.attribute_space_select_n <= 1'b0;
			else
				LINK.attribute_space_select_n <= !ATTR_SEL;
			if (REQ_READY && (WR_REQ || RD_REQ)) begin
				LINK.addr      <= REQ_ADDR;
				LINK.host_data <= REQ_DATA;
			end
		end
	end

	// ----------------------------------------
	// answers
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			DONE     <= 1'b0;
			RD_DATA  <= DATA_RST;
			CARD_IRQ <= 1'b0;
		end else begin
			DONE     <= (state != H_IDLE) && (next_state == H_IDLE);
			CARD_IRQ <= TASK_MODE ? LINK.ide_interrupt_line : !LINK.io_interrupt_request_n;
			if (!LINK.card_data_oe_n)
				RD_DATA <= LINK.card_data;
		end
	end

endmodule : chsc_host

/* File: test/chsc_checker.sv */
// checker: link rules between the card end and the host end
`timescale 1ns/1ps
module chsc_checker (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic io_write_strobe_n,
	input wire logic output_enable_strobe_n,
	input wire logic ide_mode_select_n,
	input wire logic dma_acknowledge,
	input wire logic card_data_oe_n,
	input wire logic ready,
	input wire logic dma_request
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	// ----------------------------------------
	// sequences
	// ----------------------------------------
	sequence wr_pulse;
		$fell(io_write_strobe_n) ##1 (!io_write_strobe_n) [*8];
	endsequence
	sequence oe_recent;
		!output_enable_strobe_n || !$past(output_enable_strobe_n)
			|| !$past(output_enable_strobe_n, 2) || !$past(output_enable_strobe_n, 3);
	endsequence

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_ready_after_reset: assert property ($rose(RST_N) |-> (!ready) [*8])
		else $error("ready high right after reset");
	a_oe_drive_read: assert property (!card_data_oe_n |-> oe_recent)
		else $error("card drives data without output enable");
	a_task_no_drive: assert property ((!ide_mode_select_n) [*4] |-> card_data_oe_n)
		else $error("card drives data in task mode");
	a_write_strobe_width: assert property ($fell(io_write_strobe_n) |-> wr_pulse)
		else $error("write strobe too short");
	a_access_when_ready: assert property (
		($fell(io_write_strobe_n) || $fell(output_enable_strobe_n)) |-> $past(ready))
		else $error("host access while card busy");
	a_dma_strobes_quiet: assert property (
		dma_acknowledge |-> io_write_strobe_n && output_enable_strobe_n)
		else $error("strobe during dma");
	a_ack_needs_req: assert property ($rose(dma_acknowledge) |-> dma_request)
		else $error("acknowledge without request");
	a_req_held: assert property (dma_request && !dma_acknowledge |=> dma_request)
		else $error("request dropped before acknowledge");
endmodule : chsc_checker

/* File: test/card_host_signal_control_bench.sv */
// bench: both link ends joined and driven through their user sides
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module card_host_signal_control_bench;
	import chsc_pkg::*;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic              ref_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              io_cfg = 1'b0;
	logic              lvl = 1'b0;
	logic              irq_ev = 1'b0;
	logic              dma_pend = 1'b0;
	logic              busy = 1'b0;
	logic              task_mode = 1'b0;
	logic              io_mode = 1'b0;
	logic              wr_req = 1'b0;
	logic              rd_req = 1'b0;
	logic              attr_sel = 1'b0;
	logic              udma = 1'b0;
	logic              stop_req = 1'b0;
	logic [ADDR_W-1:0] req_addr = '0;
	logic [DATA_W-1:0] req_data = '0;
	logic [DATA_W-1:0] rd_val = 16'h1234;
	logic [DATA_W-1:0] cfg_val = 16'hbe01;
	logic [DATA_W-1:0] wr_data, rd_data;
	logic [ADDR_W-1:0] wr_addr;
	logic [1:0]        mode;
	logic              wr_valid, attr_acc, dma_start, req_ready, done;
	logic              burst_end, card_irq;
	int                wv_cnt = 0;
	int                ds_cnt = 0;
	int                be_cnt = 0;
	int                wv_early = 0;
	int                bad_count = 0;
	int                total_checks = 0;
	int                cnt;

	always #4 ref_clk = ~ref_clk;

	// ----------------------------------------
	// design and checker
	// ----------------------------------------
	chsc_if chsc_if_inst ();
	chsc_card chsc_card_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(chsc_if_inst),
		.IO_CONFIGURED(io_cfg), .UDMA_ACTIVE(udma), .IRQ_LEVEL_MODE(lvl), .IRQ_EVENT(irq_ev),
		.DMA_PENDING(dma_pend), .BUSY(busy), .READ_DATA(rd_val), .CONFIG_DATA(cfg_val),
		.WRITE_DATA(wr_data), .WRITE_ADDR(wr_addr), .WRITE_VALID(wr_valid),
		.ATTR_ACCESS(attr_acc), .BURST_END(burst_end), .DMA_START(dma_start), .MODE(mode));
	chsc_host chsc_host_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(chsc_if_inst),
		.TASK_MODE(task_mode), .IO_MODE(io_mode), .UDMA_ENABLE(udma), .WR_REQ(wr_req),
		.RD_REQ(rd_req), .ATTR_SEL(attr_sel), .STOP_REQ(stop_req), .REQ_ADDR(req_addr),
		.REQ_DATA(req_data), .REQ_READY(req_ready), .DONE(done), .RD_DATA(rd_data),
		.CARD_IRQ(card_irq));
	chsc_checker chsc_checker_inst (.REF_CLK(ref_clk), .RST_N(rst_n),
		.io_write_strobe_n(chsc_if_inst.io_write_strobe_n),
		.output_enable_strobe_n(chsc_if_inst.output_enable_strobe_n),
		.ide_mode_select_n(chsc_if_inst.ide_mode_select_n),
		.dma_acknowledge(chsc_if_inst.dma_acknowledge),
		.card_data_oe_n(chsc_if_inst.card_data_oe_n), .ready(chsc_if_inst.ready),
		.dma_request(chsc_if_inst.dma_request));

	always @(posedge ref_clk) begin
		if (wr_valid === 1'b1) wv_cnt++;
		if (dma_start === 1'b1) ds_cnt++;
		if (burst_end === 1'b1) be_cnt++;
		if (wr_valid === 1'b1 && chsc_if_inst.io_write_strobe_n !== 1'b1) wv_early++;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick

	task automatic set_mode(input logic io, input logic tm);
		io_cfg = io;
		io_mode = io;
		task_mode = tm;
		tick(8);
	endtask : set_mode

	task automatic host_op(input logic wr, input logic at, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int i;
		attr_sel = at;
		req_addr = a;
		req_data = d;
		wr_req = wr;
		rd_req = !wr;
		for (i = 0; i < 500 && req_ready !== 1'b1; i++) tick(1);
		tick(1);
		wr_req = 1'b0;
		rd_req = 1'b0;
		for (i = 0; i < 100 && done !== 1'b1; i++) tick(1);
		`CHK("done", 1'b1, done)
		tick(5);
	endtask : host_op

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		#100us;
		bad_count++;
		test_done();
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk) rst_n = 1'b1;
		tick(2);
		`CHK("ready", 1'b0, chsc_if_inst.ready)
		for (int i = 0; i < 400 && chsc_if_inst.ready !== 1'b1; i++) tick(1);
		`CHK("ready", 1'b1, chsc_if_inst.ready)
		set_mode(1'b1, 1'b0);
		`CHK("mode", MODE_IO, mode)
		host_op(1'b1, 1'b0, 11'h155, 16'ha5c3);
		`CHK("write count", 1, wv_cnt)
		`CHK("write data", 16'ha5c3, wr_data)
		`CHK("write addr", 11'h155, wr_addr)
		`CHK("write edge", 0, wv_early)
		host_op(1'b0, 1'b0, 11'h010, 16'h0000);
		`CHK("io read", cfg_val, rd_data)
		set_mode(1'b0, 1'b0);
		host_op(1'b1, 1'b0, 11'h2aa, 16'h3c5a);
		`CHK("write count", 1, wv_cnt)
		for (int k = 0; k < 2; k++) begin
			host_op(1'b0, k[0], 11'h020, 16'h0000);
			`CHK("mem read", k[0] ? cfg_val : rd_val, rd_data)
			`CHK("attr", k[0], attr_acc)
		end
		set_mode(1'b1, 1'b0);
		lvl = 1'b1;
		irq_ev = 1'b1;
		tick(6);
		`CHK("irq level", 1'b0, chsc_if_inst.io_interrupt_request_n)
		`CHK("host irq", 1'b1, card_irq)
		irq_ev = 1'b0;
		tick(6);
		`CHK("irq idle", 1'b1, chsc_if_inst.io_interrupt_request_n)
		`CHK("host irq idle", 1'b0, card_irq)
		lvl = 1'b0;
		tick(2);
		irq_ev = 1'b1;
		cnt = 0;
		repeat (20) begin
			tick(1);
			if (chsc_if_inst.io_interrupt_request_n === 1'b0) cnt++;
		end
		irq_ev = 1'b0;
		`CHK("irq pulse", IRQ_PULSE_CYCLES, cnt)
		dma_pend = 1'b1;
		for (int i = 0; i < 50 && chsc_if_inst.dma_request !== 1'b1; i++) tick(1);
		`CHK("dma request", 1'b1, chsc_if_inst.dma_request)
		dma_pend = 1'b0;
		for (int i = 0; i < 100 && ds_cnt == 0; i++) tick(1);
		tick(30);
		`CHK("dma start", 1, ds_cnt)
		`CHK("no burst end", 0, be_cnt)
		udma = 1'b1;
		dma_pend = 1'b1;
		for (int i = 0; i < 50 && ds_cnt < 2; i++) tick(1);
		dma_pend = 1'b0;
		`CHK("udma select", 1'b0, chsc_if_inst.attribute_space_select_n)
		stop_req = 1'b1;
		tick(1);
		stop_req = 1'b0;
		tick(10);
		`CHK("udma start", 2, ds_cnt)
		`CHK("burst end", 1, be_cnt)
		`CHK("ack after stop", 1'b0, chsc_if_inst.dma_acknowledge)
		udma = 1'b0;
		tick(4);
		busy = 1'b1;
		tick(6);
		`CHK("busy", 1'b0, chsc_if_inst.ready)
		busy = 1'b0;
		tick(6);
		`CHK("ready", 1'b1, chsc_if_inst.ready)
		set_mode(1'b0, 1'b1);
		irq_ev = 1'b1;
		tick(6);
		`CHK("mode", MODE_TASK, mode)
		`CHK("task irq", 1'b1, chsc_if_inst.ide_interrupt_line)
		`CHK("host task irq", 1'b1, card_irq)
		irq_ev = 1'b0;
		tick(6);
		`CHK("task irq", 1'b0, chsc_if_inst.ide_interrupt_line)
		test_done();
	end
endmodule : card_host_signal_control_bench
